// *** acss_clamp.sv ***
// Conversion length clamp for the selected oscillator.
// Assumes inputs are register outputs on the same clock.
`timescale 1ns/1ps
`include "acss_map.svh"
module acss_clamp (
    input wire logic [7:0] raw_i,
    input wire logic lp_i,
    output logic [7:0] len_o
);
    import acss_pkg::*;
    // Minimum length depends on oscillator
    function automatic logic [7:0] acss_clip(input logic [7:0] x, input logic [7:0] m);
        acss_clip = (x <= m) ? m : x;
    endfunction
    // High speed floor 21, low power floor 18
    assign len_o = lp_i ? acss_clip(raw_i, `ACSS_MIN_LP) : acss_clip(raw_i, `ACSS_MIN_HS);
endmodule

// *** acss_map.svh ***
// Register offsets, field positions, reset values and clamp counts of the scan sequencer.
// Assumes inclusion by bare name from the clamp, top and bench modules.
`ifndef ACSS_MAP_SVH
`define ACSS_MAP_SVH
`define ACSS_OFF_STATUS 8'h04
`define ACSS_OFF_OSC 8'h18
`define ACSS_OFF_CLOCKS_PER_CONVERSION 8'h19
`define ACSS_OFF_LAUNCH 8'h1e
`define ACSS_OFF_CANCEL 8'h1f
`define ACSS_OFF_CHEN 8'h20
`define ACSS_BIT_FIRST 0
`define ACSS_BIT_SECOND 1
`define ACSS_BIT_LAUNCH 0
`define ACSS_BIT_CANCEL 0
`define ACSS_BIT_OSC 0
`define ACSS_POS_STATE 1
`define ACSS_RST_CHEN 2'h3
`define ACSS_RST_OSC 1'h0
`define ACSS_RST_CLOCKS_PER_CONVERSION 8'h00
`define ACSS_MIN_HS 8'h15
`define ACSS_MIN_LP 8'h12
`define ACSS_ST_OFF 2'h0
`define ACSS_ST_ON 2'h1
`define ACSS_ST_ERR 2'h3
`endif

// *** acss_osc_model.sv ***
// Conversion oscillator model: one tick every DIV reference cycles.
// Assumes the sequencer shares the reference clock and reset.
`timescale 1ns/1ps
module acss_osc_model #(
    parameter int DIV = 2
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    output logic conv_tick_o
);
    logic [7:0] cnt_reg;
    // Free running divider, the oscillator never stops
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            cnt_reg <= 8'h00;
        end else begin
            cnt_reg <= (cnt_reg == 8'(DIV - 1)) ? 8'h00 : cnt_reg + 8'h01;
        end
    end
    assign conv_tick_o = (cnt_reg == 8'(DIV - 1));
endmodule

// *** acss_pick.sv ***
// Next enabled channel finder for the scan order first then second.
// Assumes enables come from registers on the same clock.
`timescale 1ns/1ps
module acss_pick (
    input wire logic [1:0] en_i,
    input wire logic cur_i,
    input wire logic from_start_i,
    output logic found_o,
    output logic ch_o
);
    // From start pick lowest enabled; else only second after first remains
    always_comb begin
        if (from_start_i) begin
            found_o = en_i[0] | en_i[1];
            ch_o = ~en_i[0];
        end else begin
            found_o = ~cur_i & en_i[1];
            ch_o = 1'b1;
        end
    end
endmodule

// *** acss_pkg.sv ***
// Types shared by the scan sequencer modules.
// Assumes acss_map.svh is on the include path.
package acss_pkg;
    typedef enum logic [1:0] {ACSS_IDLE, ACSS_CONV, ACSS_NEXT} acss_phase_t;
    typedef logic [7:0] acss_byte_t;
endpackage

// *** acss_top.sv ***
// Channel scan sequencer with conversion timing select, registers on a byte port.
// Assumes the serial bus engine decodes transfers into one-cycle write and read strobes.
`timescale 1ns/1ps
`include "acss_map.svh"
module acss_top (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic gc_reset_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire acss_pkg::acss_byte_t addr_i,
    input wire acss_pkg::acss_byte_t wdata_i,
    input wire logic [2:0] operating_mode_select_i,
    input wire logic error_i,
    input wire logic conv_tick_i,
    output acss_pkg::acss_byte_t rdata_o,
    output logic busy_o,
    output logic conv_start_o,
    output logic conv_ch_o,
    output logic oscillator_pick_o,
    output acss_pkg::acss_byte_t clocks_per_conversion_o
);
    import acss_pkg::*;
    localparam logic [1:0] RST_CHEN = `ACSS_RST_CHEN; // Both channels selected out of reset

    typedef struct packed {
        logic scan_include_second;
        logic scan_include_first;
        logic oscillator_pick;
        logic [7:0] clk_raw;
        logic [1:0] scan_error_state;
        acss_phase_t phase;
        logic ch;
        logic [7:0] cnt;
        logic busy;
        logic conv_start;
        logic [7:0] rdata;
        logic [7:0] len;
    } acss_state_t;

    acss_state_t st_reg;
    acss_state_t st_next;
    logic [7:0] len_w;
    logic found_w;
    logic pick_ch_w;
    logic from_start_w;
    logic seq_mode_w;
    logic launch_w;
    logic cancel_w;

    // Clamped conversion length
    acss_clamp u_clamp (
        .raw_i(st_reg.clk_raw),
        .lp_i(st_reg.oscillator_pick),
        .len_o(len_w)
    );

    // Next channel in the scan
    acss_pick u_pick (
        .en_i({st_reg.scan_include_second, st_reg.scan_include_first}),
        .cur_i(st_reg.ch),
        .from_start_i(from_start_w),
        .found_o(found_w),
        .ch_o(pick_ch_w)
    );

    // Decode of operating mode and command writes
    assign seq_mode_w = operating_mode_select_i[2];
    assign launch_w = wr_i && addr_i == `ACSS_OFF_LAUNCH && wdata_i[`ACSS_BIT_LAUNCH];
    assign cancel_w = wr_i && addr_i == `ACSS_OFF_CANCEL && wdata_i[`ACSS_BIT_CANCEL];
    assign from_start_w = (st_reg.phase == ACSS_IDLE);

    // Next state of registers and scan machine
    always_comb begin
        st_next = st_reg;
        st_next.conv_start = 1'b0;
        st_next.len = len_w;
        if (wr_i) begin
            unique case (addr_i)
                `ACSS_OFF_CHEN: begin
                    st_next.scan_include_second = wdata_i[`ACSS_BIT_SECOND];
                    st_next.scan_include_first = wdata_i[`ACSS_BIT_FIRST];
                end
                `ACSS_OFF_OSC: st_next.oscillator_pick = wdata_i[`ACSS_BIT_OSC];
                `ACSS_OFF_CLOCKS_PER_CONVERSION: st_next.clk_raw = wdata_i;
                default: ;
            endcase
        end
        // Conversion scan sequence
        unique case (st_reg.phase)
            ACSS_IDLE: begin
                if (launch_w) begin
                    st_next.busy = 1'b1;
                    if (seq_mode_w) begin
                        st_next.ch = found_w ? pick_ch_w : 1'b0;
                    end else begin
                        st_next.ch = 1'b0;
                    end
                    st_next.phase = ACSS_CONV;
                    st_next.conv_start = 1'b1;
                    st_next.cnt = len_w;
                end
            end
            ACSS_CONV: begin
                if (conv_tick_i) begin
                    if (st_reg.cnt <= 8'h01) begin
                        st_next.phase = ACSS_NEXT;
                    end else begin
                        st_next.cnt = st_reg.cnt - 8'h01;
                    end
                end
            end
            ACSS_NEXT: begin
                if (seq_mode_w && found_w) begin
                    st_next.ch = pick_ch_w;
                    st_next.phase = ACSS_CONV;
                    st_next.conv_start = 1'b1;
                    st_next.cnt = len_w;
                end else begin
                    st_next.phase = ACSS_IDLE;
                    st_next.busy = 1'b0;
                end
            end
            default: begin
                st_next.phase = ACSS_IDLE;
                st_next.busy = 1'b0;
            end
        endcase
        if (cancel_w) begin
            st_next.phase = ACSS_IDLE;
            st_next.busy = 1'b0;
            st_next.conv_start = 1'b0;
        end
        // Status field: launch clears, then live mode and error
        if (launch_w) begin
            st_next.scan_error_state = `ACSS_ST_OFF;
        end else if (!seq_mode_w) begin
            st_next.scan_error_state = `ACSS_ST_OFF;
        end else if (error_i) begin
            st_next.scan_error_state = `ACSS_ST_ERR;
        end else if (st_reg.scan_error_state != `ACSS_ST_ERR) begin
            st_next.scan_error_state = `ACSS_ST_ON;
        end
        // Read data, reserved and write-only bits zero
        st_next.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `ACSS_OFF_CHEN: st_next.rdata = {6'h00, st_reg.scan_include_second,
                    st_reg.scan_include_first};
                `ACSS_OFF_STATUS: st_next.rdata = {5'h00, st_reg.scan_error_state, 1'b0};
                `ACSS_OFF_OSC: st_next.rdata = {7'h00, st_reg.oscillator_pick};
                `ACSS_OFF_CLOCKS_PER_CONVERSION: st_next.rdata = st_reg.clk_raw;
                default: st_next.rdata = 8'h00;
            endcase
        end
        if (gc_reset_i) begin
            st_next.scan_error_state = `ACSS_ST_OFF;
        end
    end

    // State register with synchronous reset
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            st_reg.scan_include_second <= RST_CHEN[`ACSS_BIT_SECOND];
            st_reg.scan_include_first <= RST_CHEN[`ACSS_BIT_FIRST];
            st_reg.oscillator_pick <= `ACSS_RST_OSC;
            st_reg.clk_raw <= `ACSS_RST_CLOCKS_PER_CONVERSION;
            st_reg.scan_error_state <= `ACSS_ST_OFF;
            st_reg.phase <= ACSS_IDLE;
            st_reg.ch <= 1'b0;
            st_reg.cnt <= 8'h00;
            st_reg.busy <= 1'b0;
            st_reg.conv_start <= 1'b0;
            st_reg.rdata <= 8'h00;
            st_reg.len <= `ACSS_MIN_HS;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs from flip-flops
    assign rdata_o = st_reg.rdata;
    assign busy_o = st_reg.busy;
    assign conv_start_o = st_reg.conv_start;
    assign conv_ch_o = st_reg.ch;
    assign oscillator_pick_o = st_reg.oscillator_pick;
    assign clocks_per_conversion_o = st_reg.len;

    // Launch raises busy next cycle
    chk_launch_busy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (launch_w && !cancel_w && st_reg.phase == ACSS_IDLE) |=> busy_o && conv_start_o)
        else $error("launch did not raise busy");
    // Cancel drops busy
    chk_cancel_busy: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        cancel_w |=> !busy_o && !conv_start_o)
        else $error("cancel did not drop busy");
    // Length floor in fast mode
    chk_len_fast: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !st_reg.oscillator_pick |=> clocks_per_conversion_o >= 8'h15)
        else $error("fast length under floor");
    // Length above the floor passes unchanged in lowpower mode
    chk_len_lp: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        st_reg.oscillator_pick && st_reg.clk_raw > 8'h12 |=> clocks_per_conversion_o == $past(st_reg.clk_raw))
        else $error("lowpower length altered");
    // Status off outside sequencing modes
    chk_status_off: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        !seq_mode_w |=> st_reg.scan_error_state == 2'h0)
        else $error("status not off");
    // Launch clears status
    chk_status_clr: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        launch_w |=> st_reg.scan_error_state == 2'h0)
        else $error("status not cleared");
    // Disabled channel never converted in sequencing mode while the other channel is enabled
    chk_skip_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        conv_start_o && seq_mode_w && !st_reg.scan_include_first && st_reg.scan_include_second
        |-> conv_ch_o)
        else $error("disabled channel zero scanned");
    chk_skip_second: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (st_reg.phase == ACSS_NEXT && !st_reg.ch && !st_reg.scan_include_second)
        |=> !conv_start_o)
        else $error("disabled channel one scanned");
    // Write-only registers read zero
    chk_wo_zero: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        rd_i && (addr_i == 8'h1e || addr_i == 8'h1f) |=> rdata_o == 8'h00)
        else $error("write-only read nonzero");

    // Scan steps, built into the properties below
    sequence s_launch_first;
        launch_w && !cancel_w && st_reg.phase == ACSS_IDLE && seq_mode_w
            && st_reg.scan_include_first;
    endsequence
    sequence s_launch_manual;
        launch_w && !cancel_w && st_reg.phase == ACSS_IDLE && !seq_mode_w;
    endsequence
    sequence s_first_done;
        st_reg.phase == ACSS_NEXT && !st_reg.ch && !cancel_w && seq_mode_w
            && st_reg.scan_include_second;
    endsequence
    sequence s_first_start;
        conv_start_o && !conv_ch_o;
    endsequence
    sequence s_second_start;
        conv_start_o && conv_ch_o;
    endsequence

    // Reset leaves both channels selected
    chk_reset_chen: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        $fell(reset_i) |-> st_reg.scan_include_second && st_reg.scan_include_first)
        else $error("channel enables not set after reset");
    // Oscillator bit follows its write
    chk_osc_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_i && addr_i == `ACSS_OFF_OSC |=> oscillator_pick_o == $past(wdata_i[`ACSS_BIT_OSC]))
        else $error("oscillator bit not written");
    // Length register keeps the raw written value
    chk_clocks_per_conversion_write: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_i && addr_i == `ACSS_OFF_CLOCKS_PER_CONVERSION |=> st_reg.clk_raw == $past(wdata_i))
        else $error("length register not written");
    // Each conversion counts the published clamped length
    chk_conv_count: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        conv_start_o |-> st_reg.cnt == clocks_per_conversion_o)
        else $error("conversion count not the clamped length");
    // First enabled channel converts first
    chk_scan_first: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        s_launch_first |=> s_first_start)
        else $error("scan did not open on channel zero");
    // Second channel follows the first when enabled
    chk_scan_second: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        s_first_done |=> s_second_start)
        else $error("scan skipped enabled channel one");
    // Scan ends after the second channel
    chk_scan_end: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        st_reg.phase == ACSS_NEXT && st_reg.ch |=> !busy_o && !conv_start_o)
        else $error("scan ran past channel one");
    // Manual modes convert channel zero once
    chk_manual_ch0: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        s_launch_manual |=> s_first_start)
        else $error("manual launch not on channel zero");
    chk_manual_once: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        st_reg.phase == ACSS_NEXT && !seq_mode_w |=> !busy_o && !conv_start_o)
        else $error("manual mode converted twice");
    // General call reset clears the status
    chk_gc_clear: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        gc_reset_i |=> st_reg.scan_error_state == `ACSS_ST_OFF)
        else $error("general call left status set");
    // Error is reported and held until cleared
    chk_err_set: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        seq_mode_w && error_i && !launch_w && !gc_reset_i
        |=> st_reg.scan_error_state == `ACSS_ST_ERR)
        else $error("error not reported");
    chk_err_hold: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        st_reg.scan_error_state == `ACSS_ST_ERR && seq_mode_w && !launch_w && !gc_reset_i
        |=> st_reg.scan_error_state == `ACSS_ST_ERR)
        else $error("error status not held");
    // Zero writes to the command registers are inert
    chk_zero_launch: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_i && addr_i == `ACSS_OFF_LAUNCH && !wdata_i[`ACSS_BIT_LAUNCH]
        && st_reg.phase == ACSS_IDLE |=> !busy_o && !conv_start_o)
        else $error("zero launch write started a scan");
    chk_zero_cancel: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        wr_i && addr_i == `ACSS_OFF_CANCEL && !wdata_i[`ACSS_BIT_CANCEL]
        && st_reg.phase == ACSS_CONV |=> busy_o)
        else $error("zero cancel write stopped a scan");
endmodule

// *** acss_top_test.sv ***
// Self-checking bench for the scan sequencer byte register port.
// Assumes acss_map.svh, acss_pkg and the oscillator model compile first.
`timescale 1ns/1ps
`include "acss_map.svh"
module acss_top_test;
    import acss_pkg::*;
    logic ref_clk_i = 1'b0;
    logic reset_i = 1'b1;
    logic gc_reset_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    acss_byte_t addr_i = 8'h00;
    acss_byte_t wdata_i = 8'h00;
    logic [2:0] mode = 3'h0;
    logic error_i = 1'b0;
    logic conv_tick_i;
    acss_byte_t rdata_o, clocks_per_conversion_o;
    logic busy_o, conv_start_o, conv_ch_o, oscillator_pick_o;
    acss_byte_t raws [6] = '{8'h00, 8'h15, 8'h16, 8'h12, 8'h13, 8'h00};
    acss_byte_t exps [6] = '{8'h15, 8'h15, 8'h16, 8'h12, 8'h13, 8'h12};
    int n_fail = 0;
    int tests_run = 0;
    int cycles = 0;
    int n, st, len;
    logic ch;
    time wr_drop = 0;
    time rd_drop = 0;

    acss_top u_acss_top (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .gc_reset_i(gc_reset_i),
        .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .operating_mode_select_i(mode), .error_i(error_i), .conv_tick_i(conv_tick_i),
        .rdata_o(rdata_o), .busy_o(busy_o), .conv_start_o(conv_start_o),
        .conv_ch_o(conv_ch_o), .oscillator_pick_o(oscillator_pick_o),
        .clocks_per_conversion_o(clocks_per_conversion_o));
    acss_osc_model #(.DIV(2)) u_acss_osc_model (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .conv_tick_o(conv_tick_i));

    // Clock and hang guard
    always #2 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Strobes rise after a falling edge and drop one cycle later;
    // a call right after the same strobe dropped waits a cycle so it is never re-driven at once
    task automatic wr(input acss_byte_t a, input acss_byte_t d);
        if (wr_drop == $time) begin
            @(negedge ref_clk_i);
        end
        addr_i = a;
        wdata_i = d;
        wr_i = 1'b1;
        @(negedge ref_clk_i);
        wr_i = 1'b0;
        wr_drop = $time;
    endtask
    task automatic rd(input acss_byte_t a, input acss_byte_t exp);
        if (rd_drop == $time) begin
            @(negedge ref_clk_i);
        end
        addr_i = a;
        rd_i = 1'b1;
        @(negedge ref_clk_i);
        rd_i = 1'b0;
        rd_drop = $time;
        check(rdata_o, exp);
    endtask
    // Runs until busy drops, counting later starts and the last channel
    task automatic run_out(output int k, output int s, output logic c);
        k = 0;
        s = 0;
        c = conv_ch_o;
        while (busy_o !== 1'b0 && k < 600) begin
            @(negedge ref_clk_i);
            k++;
            if (conv_start_o === 1'b1) begin
                s++;
                c = conv_ch_o;
            end
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (4) @(negedge ref_clk_i);
        reset_i = 1'b0;
        rd(`ACSS_OFF_CHEN, 8'h03);
        rd(`ACSS_OFF_OSC, 8'h00);
        rd(`ACSS_OFF_STATUS, 8'h00);
        rd(`ACSS_OFF_LAUNCH, 8'h00);
        rd(`ACSS_OFF_CANCEL, 8'h00);
        check(clocks_per_conversion_o, 8'h15);
        $display("Reset test done");
        // Length floors for both oscillators
        for (int i = 0; i < 6; i++) begin
            wr(`ACSS_OFF_OSC, 8'(i > 2));
            wr(`ACSS_OFF_CLOCKS_PER_CONVERSION, raws[i]);
            @(negedge ref_clk_i);
            check(clocks_per_conversion_o, exps[i]);
            check({7'h00, oscillator_pick_o}, 8'(i > 2));
        end
        rd(`ACSS_OFF_CLOCKS_PER_CONVERSION, 8'h00);
        $display("Clamp test done");
        // Scans over each channel mix with a channel enabled, first with the low power oscillator
        mode = 3'h4;
        for (int j = 1; j < 4; j++) begin
            len = (j == 1) ? 18 : 21;
            wr(`ACSS_OFF_OSC, 8'(j == 1));
            wr(`ACSS_OFF_CHEN, 8'(j));
            wr(`ACSS_OFF_LAUNCH, 8'h01);
            check(8'({busy_o, conv_start_o}), 8'h03);
            check(8'(conv_ch_o), 8'(j == 2));
            run_out(n, st, ch);
            check(8'(st), 8'(j == 3));
            check(8'(ch), 8'(j != 1));
            check(8'(n >= (2 * len - 2) * (st + 1) && n <= (2 * len + 4) * (st + 1)), 8'h01);
            rd(`ACSS_OFF_STATUS, 8'h02);
        end
        $display("Scan test done");
        // Manual mode runs one first channel conversion only
        mode = 3'h0;
        wr(`ACSS_OFF_CHEN, 8'h02);
        wr(`ACSS_OFF_LAUNCH, 8'h01);
        check(8'(conv_ch_o), 8'h00);
        run_out(n, st, ch);
        check(8'(st), 8'h00);
        rd(`ACSS_OFF_STATUS, 8'h00);
        // Zero writes are inert, a one cancels
        mode = 3'h6;
        wr(`ACSS_OFF_LAUNCH, 8'h00);
        check(8'(busy_o), 8'h00);
        wr(`ACSS_OFF_LAUNCH, 8'h01);
        repeat (5) @(negedge ref_clk_i);
        wr(`ACSS_OFF_CANCEL, 8'h00);
        check(8'(busy_o), 8'h01);
        wr(`ACSS_OFF_CANCEL, 8'h01);
        check(8'(busy_o), 8'h00);
        rd(`ACSS_OFF_STATUS, 8'h02);
        $display("Cancel test done");
        // Sticky error, cleared by launch and by general call reset
        error_i = 1'b1;
        @(negedge ref_clk_i);
        error_i = 1'b0;
        rd(`ACSS_OFF_STATUS, 8'h06);
        wr(`ACSS_OFF_LAUNCH, 8'h01);
        run_out(n, st, ch);
        rd(`ACSS_OFF_STATUS, 8'h02);
        error_i = 1'b1;
        @(negedge ref_clk_i);
        error_i = 1'b0;
        gc_reset_i = 1'b1;
        @(negedge ref_clk_i);
        gc_reset_i = 1'b0;
        rd(`ACSS_OFF_STATUS, 8'h00);
        rd(`ACSS_OFF_STATUS, 8'h02);
        // Device reset in mid scan
        wr(`ACSS_OFF_LAUNCH, 8'h01);
        reset_i = 1'b1;
        @(negedge ref_clk_i);
        reset_i = 1'b0;
        rd(`ACSS_OFF_STATUS, 8'h00);
        check(8'(busy_o), 8'h00);
        rd(`ACSS_OFF_CHEN, 8'h03);
        $display("Error test done");
        end_of_test();
    end
endmodule
